// *** fdcmd_defs.svh ***
// Offsets, field positions, reset values and timing counts of the command decoder
`ifndef FDCMD_DEFS_SVH
`define FDCMD_DEFS_SVH
`define FDCMD_OFF_MSR       12'h000
`define FDCMD_OFF_DATA      12'h004
`define FDCMD_OFF_DRV       12'h008
`define FDCMD_OFF_SET       12'h00C
`define FDCMD_OP_RECAL      8'h07
`define FDCMD_OP_SEEK       8'h0F
`define FDCMD_OP_SENSEI     8'h08
`define FDCMD_OP_SENSED     8'h04
`define FDCMD_OP_DUMP       8'h0E
`define FDCMD_ST0_INVALID   8'h80
`define FDCMD_ST0_SEEKEND   8'h20
`define FDCMD_MSR_RQM       7
`define FDCMD_MSR_DIO       6
`define FDCMD_MSR_BUSY      4
`define FDCMD_SET_RESET     32'h0000_0000
`define FDCMD_STEP_NS       1000
`define FDCMD_STEP_CYC      ((`FDCMD_STEP_NS + 9) / 10)
`endif

// *** fdcmd_pkg.sv ***
// Types shared by the command decoder
package fdcmd_pkg;
    typedef enum logic [4:0] {
        FDCMD_IDLE   = 5'h01,
        FDCMD_PARAM  = 5'h02,
        FDCMD_EXEC   = 5'h04,
        FDCMD_RESULT = 5'h08,
        FDCMD_WAIT   = 5'h10
    } fdcmd_state_e;
    typedef struct packed {
        logic       track0_n;
        logic       wprot_n;
        logic       ready;
    } fdcmd_drive_in_s;
    typedef struct packed {
        logic       step;
        logic       dir_in;
        logic [1:0] drive_sel;
        logic       head_sel;
    } fdcmd_drive_out_s;
endpackage : fdcmd_pkg

// *** fdcmd_decoder.sv ***
// Floppy command decoder: APB slave, command/result FIFO, seek engine
`include "fdcmd_defs.svh"
module fdcmd_decoder #(
    parameter int STEP_CYC = `FDCMD_STEP_CYC
) (
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic                        clk_en,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [11:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire fdcmd_pkg::fdcmd_drive_in_s  drive_in,
    output fdcmd_pkg::fdcmd_drive_out_s      drive_out,
    output logic                             irq
);
    import fdcmd_pkg::*;

    // Step timer is 16 bits wide and needs at least two idle cycles between pulses
    if (STEP_CYC < 2 || STEP_CYC > 32'h0000_FFFF) begin : g_bad_step
        $error("STEP_CYC out of range");
    end

    // Pin synchroniser, three stages; second and third must agree
    logic [2:0] s1, s2, s3, pin_q;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s1 <= 3'h7; s2 <= 3'h7; s3 <= 3'h7; pin_q <= 3'h7;
        end else if (clk_en) begin
            s1 <= drive_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) pin_q <= s3;
        end
    end
    wire track0 = ~pin_q[2];                    // Head at cylinder zero

    fdcmd_state_e     state;                    // Command phase
    logic [7:0]       opcode;                   // Latched command byte
    logic [1:0]       pcnt;                     // Parameter bytes received
    logic [1:0]       drv;                      // Selected drive
    logic             head;                     // Selected head
    logic [7:0]       target_cylinder;          // Seek goal
    logic [7:0]       present_cylinder [4];     // Per-drive position
    logic [7:0]       res [10];                 // Result bytes
    logic [3:0]       rcnt, ridx;               // Result length, read index
    logic             recal;                    // Recalibrate in progress
    logic [15:0]      step_tmr;                 // Step pacing
    logic [7:0]       status_zero_byte;         // Last completion status
    logic [31:0]      settings;                 // Software settings word
    logic             int_pend;                 // Completion interrupt

    // APB: zero-wait answer, errors on unmapped offsets
    wire acc   = psel & penable & clk_en;
    wire wr    = acc & pwrite;
    wire rd    = acc & ~pwrite;
    wire a_dat = paddr == `FDCMD_OFF_DATA;
    wire mapped = a_dat | (paddr == `FDCMD_OFF_MSR) | (paddr == `FDCMD_OFF_DRV) | (paddr == `FDCMD_OFF_SET);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Main status: host may write when waiting for bytes, read in results
    wire rqm = (state == FDCMD_IDLE) | (state == FDCMD_PARAM) | (state == FDCMD_RESULT);
    wire dio = state == FDCMD_RESULT;
    wire [7:0] msr = {rqm, dio, 1'b0, ~(state == FDCMD_IDLE), 4'h0};

    wire cmd_wr = wr & a_dat & ((state == FDCMD_IDLE) | (state == FDCMD_PARAM));
    wire res_rd = rd & a_dat & (state == FDCMD_RESULT);

    // Parameters needed per opcode
    function automatic logic [1:0] nparams(input logic [7:0] op);
        case (op)
            `FDCMD_OP_RECAL:  nparams = 2'd1;
            `FDCMD_OP_SEEK:   nparams = 2'd2;
            `FDCMD_OP_SENSED: nparams = 2'd1;
            default:          nparams = 2'd0;
        endcase
    endfunction : nparams

    wire dest_reached = recal ? track0 : (present_cylinder[drv] == target_cylinder);

    // Phase sequencer
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= FDCMD_IDLE;
            opcode <= 8'h00; pcnt <= 2'd0; drv <= 2'd0; head <= 1'b0;
            target_cylinder <= 8'h00; recal <= 1'b0; rcnt <= 4'h0; ridx <= 4'h0;
            for (int i = 0; i < 10; i++) res[i] <= 8'h00;
        end else if (clk_en) begin
            case (state)
                FDCMD_IDLE: begin
                    if (cmd_wr) begin
                        opcode <= pwdata[7:0];
                        pcnt <= 2'd0;
                        ridx <= 4'h0;
                        case (pwdata[7:0])
                            `FDCMD_OP_RECAL, `FDCMD_OP_SEEK, `FDCMD_OP_SENSED: state <= FDCMD_PARAM;
                            `FDCMD_OP_SENSEI: begin
                                res[0] <= status_zero_byte;
                                res[1] <= present_cylinder[drv];
                                rcnt <= 4'd2;
                                state <= FDCMD_RESULT;
                            end
                            `FDCMD_OP_DUMP: begin
                                for (int i = 0; i < 4; i++) res[i] <= present_cylinder[i];
                                for (int i = 0; i < 4; i++) res[4+i] <= settings[8*i +: 8];
                                res[8] <= 8'h00;
                                res[9] <= 8'h00;
                                rcnt <= 4'd10;
                                state <= FDCMD_RESULT;
                            end
                            default: begin
                                res[0] <= `FDCMD_ST0_INVALID;
                                rcnt <= 4'd1;
                                state <= FDCMD_RESULT;
                            end
                        endcase
                    end
                end
                FDCMD_PARAM: begin
                    if (cmd_wr) begin
                        pcnt <= pcnt + 2'd1;
                        if (pcnt == 2'd0) begin
                            drv <= pwdata[1:0];
                            head <= pwdata[2];
                        end else begin
                            target_cylinder <= pwdata[7:0];
                        end
                        if (pcnt + 2'd1 == nparams(opcode)) begin
                            if (opcode == `FDCMD_OP_SENSED) begin
                                res[0] <= {1'b0, ~pin_q[1], pin_q[0], track0, 1'b1, pwdata[2:0]};
                                rcnt <= 4'd1;
                                state <= FDCMD_RESULT;
                            end else begin
                                recal <= opcode == `FDCMD_OP_RECAL;
                                state <= FDCMD_EXEC;
                            end
                        end
                    end
                end
                FDCMD_EXEC: begin
                    if (dest_reached && step_tmr == 16'h0000) begin
                        recal <= 1'b0;
                        state <= FDCMD_IDLE;
                    end
                end
                FDCMD_RESULT: begin
                    if (res_rd) begin
                        ridx <= ridx + 4'd1;
                        if (ridx + 4'd1 == rcnt) state <= FDCMD_IDLE;
                    end
                end
                default: state <= FDCMD_IDLE;
            endcase
        end
    end

    // Step engine: one pulse per period until destination
    always_ff @(posedge core_clk) begin
        if (rst) begin
            step_tmr <= 16'h0000;
            drive_out <= '0;
            for (int i = 0; i < 4; i++) present_cylinder[i] <= 8'h00;
        end else if (clk_en) begin
            drive_out.drive_sel <= drv;
            drive_out.head_sel <= head;
            drive_out.step <= 1'b0;
            if (step_tmr != 16'h0000) begin
                step_tmr <= step_tmr - 16'h0001;
            end else if (state == FDCMD_EXEC && !dest_reached) begin
                drive_out.step <= 1'b1;
                step_tmr <= 16'(STEP_CYC);
                if (recal || target_cylinder < present_cylinder[drv]) begin
                    drive_out.dir_in <= 1'b0;
                    present_cylinder[drv] <= present_cylinder[drv] - 8'h01;
                end else begin
                    drive_out.dir_in <= 1'b1;
                    present_cylinder[drv] <= present_cylinder[drv] + 8'h01;
                end
            end else if (state == FDCMD_EXEC && recal) begin
                present_cylinder[drv] <= 8'h00;
            end
        end
    end

    // Completion interrupt and status; set beats a sense clear
    wire done = state == FDCMD_EXEC && dest_reached && step_tmr == 16'h0000;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            int_pend <= 1'b0;
            status_zero_byte <= 8'h00;
            settings <= `FDCMD_SET_RESET;
        end else if (clk_en) begin
            if (done) begin
                int_pend <= 1'b1;
                status_zero_byte <= `FDCMD_ST0_SEEKEND | {5'h00, head, drv};
            end else if (cmd_wr && state == FDCMD_IDLE && pwdata[7:0] == `FDCMD_OP_SENSEI) begin
                int_pend <= 1'b0;
            end
            if (wr && paddr == `FDCMD_OFF_SET) settings <= pwdata;
        end
    end
    assign irq = int_pend;

    // Read data from flip-flops
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en && psel && !penable && !pwrite) begin
            case (paddr)
                `FDCMD_OFF_MSR:  prdata <= {24'h000000, msr};
                `FDCMD_OFF_DATA: prdata <= {24'h000000, res[ridx]};
                `FDCMD_OFF_DRV:  prdata <= {16'h0000, present_cylinder[drv], 6'h00, drv};
                `FDCMD_OFF_SET:  prdata <= settings;
                default:         prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Checks
    a_invalid_result: assert property (@(posedge core_clk) disable iff (rst)
        (clk_en && cmd_wr && state == FDCMD_IDLE && pwdata[7:0] == 8'hFF) |=> (res[0] == 8'h80 && rcnt == 4'd1))
        else $error("invalid opcode result wrong");
    a_invalid_nostep: assert property (@(posedge core_clk) disable iff (rst)
        (state == FDCMD_RESULT && opcode == 8'hFF) |-> !drive_out.step)
        else $error("step during no-op");
    a_msr_result: assert property (@(posedge core_clk) disable iff (rst)
        (state == FDCMD_RESULT) |-> (rqm && dio))
        else $error("status bits stale");
    a_exec_norqm: assert property (@(posedge core_clk) disable iff (rst)
        (state == FDCMD_EXEC) |-> !rqm)
        else $error("request during execution");
    a_sense_two: assert property (@(posedge core_clk) disable iff (rst)
        (clk_en && cmd_wr && state == FDCMD_IDLE && pwdata[7:0] == 8'h08) |=> (rcnt == 4'd2))
        else $error("sense interrupt length");
    a_sensed_one: assert property (@(posedge core_clk) disable iff (rst)
        (clk_en && cmd_wr && state == FDCMD_PARAM && opcode == 8'h04) |=> (rcnt == 4'd1 && state == FDCMD_RESULT))
        else $error("sense drive length");
    a_dump_len: assert property (@(posedge core_clk) disable iff (rst)
        (clk_en && cmd_wr && state == FDCMD_IDLE && pwdata[7:0] == 8'h0E) |=> (rcnt == 4'd10))
        else $error("dump length");
    a_recal_out: assert property (@(posedge core_clk) disable iff (rst)
        (drive_out.step && recal) |-> !drive_out.dir_in)
        else $error("recalibrate stepped inward");
    a_done_irq: assert property (@(posedge core_clk) disable iff (rst)
        (clk_en && done) |=> irq)
        else $error("no completion interrupt");
    a_idle_after: assert property (@(posedge core_clk) disable iff (rst)
        (clk_en && res_rd && ridx + 4'd1 == rcnt) |=> state == FDCMD_IDLE)
        else $error("not idle after results");
endmodule : fdcmd_decoder

// *** fcd_drive_model.sv ***
// Behavioural floppy drive: head position, track-zero sensor, write-protect and ready pins
module fcd_drive_model #(
    parameter int START_CYL = 5                  // Head position at power-up
) (
    input  wire logic                         core_clk,
    input  wire fdcmd_pkg::fdcmd_drive_out_s  drive_out,
    output fdcmd_pkg::fdcmd_drive_in_s        drive_in,
    output int                                cyl
);
    timeunit 1ns;
    timeprecision 1ps;
    import fdcmd_pkg::*;

    // Head starts away from track zero so that a return to it takes real steps
    initial begin
        cyl = START_CYL;
    end

    // One step pulse moves the head one track; the end stop holds it at track zero
    always @(posedge core_clk) begin
        if (drive_out.step === 1'b1) begin
            if (drive_out.dir_in === 1'b1) begin
                cyl <= cyl + 1;
            end else if (cyl > 0) begin
                cyl <= cyl - 1;
            end
        end
    end

    // Sensor is active low; disk unprotected and drive always ready
    // One driver for the whole pin bundle: track0_n, wprot_n, ready
    assign drive_in = {(cyl != 0), 1'b1, 1'b1};
endmodule : fcd_drive_model

// *** floppy_command_decoder_test.sv ***
// Self-checking bench for the command decoder with a drive model on its far side
`include "fdcmd_defs.svh"
module floppy_command_decoder_test;
    timeunit 1ns;
    timeprecision 1ps;
    import fdcmd_pkg::*;

    logic             core_clk, rst, clk_en, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0]      paddr;
    logic [31:0]      pwdata, prdata;
    fdcmd_drive_in_s  drive_in;
    fdcmd_drive_out_s drive_out;
    int               cyl;                    // Head position inside the model
    int               err_total, checks_done, steps_seen, cycles;

    // Short step time keeps head moves to a few cycles
    fdcmd_decoder #(.STEP_CYC(2)) uut (
        .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .drive_in(drive_in), .drive_out(drive_out), .irq(irq));

    fcd_drive_model #(.START_CYL(5)) drive (
        .core_clk(core_clk), .drive_out(drive_out), .drive_in(drive_in), .cyl(cyl));

    // Clock, step counter and hang guard
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (drive_out.step === 1'b1) begin
            steps_seen <= steps_seen + 1;
        end
        if (cycles == 20000) begin
            err_total = err_total + 1;
            finish_test();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One APB transfer, then an idle edge so the next setup never collides with the release
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait for the answer
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    // Poll the main status until it grants a byte in the wanted direction
    task automatic wait_msr(input logic dio);
        logic [31:0] d;
        logic        e;
        int          n;
        n = 0;
        do begin
            apb(1'b0, `FDCMD_OFF_MSR, 32'h0, d, e);
            n++;
        end while ((d[7] !== 1'b1 || d[6] !== dio) && n < 100);
        check("msr rqm dio", {d[7], d[6]}, {1'b1, dio});
    endtask : wait_msr

    task automatic put(input logic [7:0] b);
        logic [31:0] d;
        logic        e;
        wait_msr(1'b0);
        apb(1'b1, `FDCMD_OFF_DATA, {24'h0, b}, d, e);
    endtask : put

    task automatic get(input string what, input logic [7:0] exp);
        logic [31:0] d;
        logic        e;
        wait_msr(1'b1);
        apb(1'b0, `FDCMD_OFF_DATA, 32'h0, d, e);
        check(what, d[7:0], exp);
    endtask : get

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 300) begin
            @(posedge core_clk);
            n++;
        end
        check("irq raised", irq, 1'b1);
    endtask : wait_irq

    // Idle state, unmapped address and settings reset value
    task automatic t_reset();
        logic [31:0] d;
        logic        e;
        check("irq reset", irq, 1'b0);
        check("pready tied", pready, 1'b1);
        check("drive_out reset", drive_out, 5'h00);
        apb(1'b0, `FDCMD_OFF_MSR, 32'h0, d, e);
        check("msr idle", {d[7], d[6], d[4]}, 3'b100);
        apb(1'b0, 12'h010, 32'h0, d, e);
        check("unmapped err", e, 1'b1);
        check("unmapped data", d, 32'h0);
        apb(1'b0, `FDCMD_OFF_SET, 32'h0, d, e);
        check("settings reset", d, `FDCMD_SET_RESET);
    endtask : t_reset

    // Unknown opcode, with a byte pushed into the result phase that must be ignored
    task automatic t_invalid();
        logic [31:0] d;
        logic        e;
        int          s0;
        s0 = steps_seen;
        put(8'hFF);
        apb(1'b1, `FDCMD_OFF_DATA, 32'h0000_0008, d, e);
        get("invalid st0", `FDCMD_ST0_INVALID);
        wait_msr(1'b0);
        check("invalid no steps", steps_seen - s0, 0);
        check("invalid no irq", irq, 1'b0);
    endtask : t_invalid

    // Recalibrate then seek on drive 1, each acknowledged by sense interrupt
    task automatic t_moves();
        logic [31:0] d;
        logic        e;
        int          s0;
        put(`FDCMD_OP_RECAL);
        put(8'h01);
        wait_irq();
        check("recal track0", cyl, 0);
        check("recal drive", drive_out.drive_sel, 2'b01);
        put(`FDCMD_OP_SENSEI);
        get("recal st0", `FDCMD_ST0_SEEKEND | 8'h01);
        get("recal cyl", 8'h00);
        check("irq cleared", irq, 1'b0);
        s0 = steps_seen;
        put(`FDCMD_OP_SEEK);
        put(8'h05);
        put(8'h03);
        wait_irq();
        check("seek cyl", cyl, 3);
        check("seek steps", steps_seen - s0, 3);
        check("seek dir head", {drive_out.dir_in, drive_out.head_sel}, 2'b11);
        put(`FDCMD_OP_SENSEI);
        get("seek st0", `FDCMD_ST0_SEEKEND | 8'h05);
        get("seek cyl byte", 8'h03);
        // Position view: cylinder of selected drive above the drive number
        apb(1'b0, `FDCMD_OFF_DRV, 32'h0, d, e);
        check("drive position", d, 32'h0000_0301);
    endtask : t_moves

    // Drive status of drive 1 head 1, then dump of cylinders and settings
    task automatic t_status();
        logic [31:0] d;
        logic        e;
        logic [7:0]  exp [10];
        put(`FDCMD_OP_SENSED);
        put(8'h05);
        get("drive status", 8'h2D);
        wait_msr(1'b0);
        apb(1'b1, `FDCMD_OFF_SET, 32'h4433_2211, d, e);
        exp = '{8'h00, 8'h03, 8'h00, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'h00};
        put(`FDCMD_OP_DUMP);
        foreach (exp[i]) begin
            get("dump byte", exp[i]);
        end
        wait_msr(1'b0);
    endtask : t_status

    // Clock enable low freezes state, so a settings write then is lost
    task automatic t_freeze();
        logic [31:0] d;
        logic        e;
        clk_en <= 1'b0;
        apb(1'b1, `FDCMD_OFF_SET, 32'h0000_0055, d, e);
        clk_en <= 1'b1;
        apb(1'b0, `FDCMD_OFF_SET, 32'h0, d, e);
        check("frozen settings", d, 32'h4433_2211);
    endtask : t_freeze

    task automatic finish_test();
        $display("Checks %0d, errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    // Reset for twelve cycles, then the scenarios in turn
    initial begin
        err_total = 0;
        checks_done = 0;
        steps_seen = 0;
        cycles = 0;
        rst = 1'b1;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_invalid();
        t_moves();
        t_status();
        t_freeze();
        finish_test();
    end
endmodule : floppy_command_decoder_test
